// ==== hw/rsc_cfg.svh ====
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
`define RSC_CLK_HZ         25000000
`define RSC_PULSE_MS       350
`define RSC_SWAP_MIN_MS    100
`define RSC_DEBOUNCE_MS    10
`define RSC_HEALTH_HALF_MS 1000
`define RSC_SETTLE_MS      1000
`define RSC_MS_CYCLES      (`RSC_CLK_HZ / 1000)
`endif

// ==== hw/rsc_ctrl.sv ====
// Notes on behaviour
// - mode pin open means automatic, grounded means manual
// - automatic: online unit fault moves both switches to the other unit
// - no automatic switchover while offline unit is also faulted
// - remote mode applies only with pin open; grounded pin forces manual
// - automatic: swap request acts only if offline unit is healthy
// - manual: every swap request made outside a pulse or settle period moves both switches
// - remote swap command acts like a swap pin pulse but needs no 100 ms minimum hold
// - half hertz health square wave while all is well, stopped on problem
// - online contacts close for the online unit
// - fault contacts close for a faulted unit
// - redundancy flags driven to both units
// - address offset output driven to unit B
// - switch moved by one 350 ms pulse on position A or B line
// - position outputs grounded for the online unit, open otherwise
`include "rsc_cfg.svh"
module rsc_ctrl
    import rsc_pkg::*;
#(
    parameter int PULSE_MS       = `RSC_PULSE_MS,
    parameter int SWAP_MIN_MS    = `RSC_SWAP_MIN_MS,
    parameter int HEALTH_HALF_MS = `RSC_HEALTH_HALF_MS,
    parameter int SETTLE_MS      = `RSC_SETTLE_MS,
    parameter int MS_CYCLES      = `RSC_MS_CYCLES
)
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  redundancy_mode_select,
    input  wire logic  swap_request_n,
    input  wire logic  remote_swap_command,
    input  wire logic  remote_mode_manual,
    input  wire logic  unit_a_health_input,
    input  wire logic  unit_b_health_input,
    input  rsc_sw_ind_s tx_ind_n,
    input  rsc_sw_ind_s rx_ind_n,
    output rsc_sw_cmd_s tx_cmd,
    output rsc_sw_cmd_s rx_cmd,
    output logic       unit_a_online_contact,
    output logic       unit_b_online_contact,
    output logic       unit_a_fault_contact,
    output logic       unit_b_fault_contact,
    output logic       unit_a_position_n,
    output logic       unit_b_position_n,
    output logic       controller_health_pulse,
    output logic       unit_a_redundant_flag_n,
    output logic       unit_b_redundant_flag_n,
    output logic       unit_b_address_offset_n,
    output logic       manual_mode,
    output logic       switch_problem
);
    localparam logic [15:0] MS_CNT  = 16'(MS_CYCLES);
    localparam logic [15:0] P_MS    = 16'(PULSE_MS);
    localparam logic [15:0] H_MS    = 16'(HEALTH_HALF_MS);
    localparam logic [15:0] S_MS    = 16'(SETTLE_MS);

    logic        ms_tick;
    logic [15:0] div_q;
    logic [15:0] div_d;
    logic        mode_f;
    logic        swap_f;
    logic        a_ok_f;
    logic        b_ok_f;
    logic        txa_f;
    logic        txb_f;
    logic        rxa_f;
    logic        rxb_f;

    assign ms_tick = (div_q + 16'h0001 >= MS_CNT);

    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_mode (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(redundancy_mode_select), .clean(mode_f));
    rsc_filter #(.HOLD_MS(SWAP_MIN_MS)) u_swap (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(swap_request_n), .clean(swap_f));
    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_fa (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(unit_a_health_input), .clean(a_ok_f));
    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_fb (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(unit_b_health_input), .clean(b_ok_f));
    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_ta (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(tx_ind_n.pos_a_ind), .clean(txa_f));
    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_tb (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(tx_ind_n.pos_b_ind), .clean(txb_f));
    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_ra (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(rx_ind_n.pos_a_ind), .clean(rxa_f));
    rsc_filter #(.HOLD_MS(`RSC_DEBOUNCE_MS)) u_rb (.clk(clk), .rst(rst), .ms_tick(ms_tick),
        .raw(rx_ind_n.pos_b_ind), .clean(rxb_f));

    logic       a_fault;
    logic       b_fault;
    logic       manual;
    logic       ind_a;
    logic       ind_b;
    logic       online_b;
    logic       swap_prev_q;
    logic       swap_evt;
    logic       want;
    rsc_state_e st_q;
    rsc_state_e st_d;
    logic       tgt_q;
    logic       tgt_d;
    logic [15:0] tm_q;
    logic [15:0] tm_d;
    logic       prob_q;
    logic       prob_d;
    logic [15:0] hc_q;
    logic [15:0] hc_d;
    logic       hw_q;
    logic       hw_d;

    // divider restarts as a pulse starts so the pulse spans whole milliseconds
    always_comb
    begin
        div_d = (div_q + 16'h0001 >= MS_CNT) ? 16'h0000 : div_q + 16'h0001;
        if (st_q == RSC_IDLE && want)
        begin
            div_d = 16'h0000;
        end
    end

    assign a_fault = a_ok_f;
    assign b_fault = b_ok_f;
    assign manual  = ~mode_f | remote_mode_manual;
    assign ind_a   = ~txa_f & ~rxa_f & txb_f & rxb_f;
    assign ind_b   = ~txb_f & ~rxb_f & txa_f & rxa_f;
    assign online_b = ind_b | (~ind_a & tgt_q);
    assign swap_evt = (~swap_f & swap_prev_q) | remote_swap_command;

    always_comb
    begin
        want = 1'b0;
        if (swap_evt)
        begin
            if (manual)
            begin
                want = 1'b1;
            end
            else
            begin
                want = online_b ? ~a_fault : ~b_fault;
            end
        end
        else if (!manual)
        begin
            want = online_b ? (b_fault & ~a_fault)
                            : (a_fault & ~b_fault);
        end
    end

    always_comb
    begin
        st_d   = st_q;
        tgt_d  = tgt_q;
        tm_d   = tm_q;
        prob_d = prob_q;
        case (st_q)
            RSC_IDLE:
            begin
                if (want)
                begin
                    tgt_d = ~online_b;
                    tm_d  = 16'h0000;
                    st_d  = RSC_PULSE;
                end
                else if (online_b != tgt_q || !(ind_a | ind_b))
                begin
                    prob_d = 1'b1;
                end
                else
                begin
                    prob_d = 1'b0;
                end
            end
            RSC_PULSE:
            begin
                if (ms_tick)
                begin
                    tm_d = tm_q + 16'h0001;
                    if (tm_q + 16'h0001 >= P_MS)
                    begin
                        tm_d = 16'h0000;
                        st_d = RSC_SETTLE;
                    end
                end
            end
            RSC_SETTLE:
            begin
                if (ms_tick)
                begin
                    tm_d = tm_q + 16'h0001;
                    if (tm_q + 16'h0001 >= S_MS)
                    begin
                        st_d = RSC_IDLE;
                    end
                end
            end
            default:
            begin
                st_d = RSC_IDLE;
            end
        endcase
    end

    always_comb
    begin
        hc_d = hc_q;
        hw_d = hw_q;
        if (prob_q)
        begin
            hc_d = 16'h0000;
            hw_d = 1'b0;
        end
        else if (ms_tick)
        begin
            if (hc_q + 16'h0001 >= H_MS)
            begin
                hc_d = 16'h0000;
                hw_d = ~hw_q;
            end
            else
            begin
                hc_d = hc_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_q       <= 16'h0000;
            swap_prev_q <= 1'b1;
            st_q        <= RSC_IDLE;
            tgt_q       <= 1'b0;
            tm_q        <= 16'h0000;
            prob_q      <= 1'b0;
            hc_q        <= 16'h0000;
            hw_q        <= 1'b0;
        end
        else
        begin
            div_q       <= div_d;
            swap_prev_q <= swap_f;
            st_q        <= st_d;
            tgt_q       <= tgt_d;
            tm_q        <= tm_d;
            prob_q      <= prob_d;
            hc_q        <= hc_d;
            hw_q        <= hw_d;
        end
    end

    always_comb
    begin
        tx_cmd.pos_a_cmd = (st_q == RSC_PULSE) & ~tgt_q;
        tx_cmd.pos_b_cmd = (st_q == RSC_PULSE) & tgt_q;
        rx_cmd.pos_a_cmd = (st_q == RSC_PULSE) & ~tgt_q;
        rx_cmd.pos_b_cmd = (st_q == RSC_PULSE) & tgt_q;
    end

    assign unit_a_online_contact   = ~online_b;
    assign unit_b_online_contact   = online_b;
    assign unit_a_fault_contact    = a_fault;
    assign unit_b_fault_contact    = b_fault;
    assign unit_a_position_n       = online_b;
    assign unit_b_position_n       = ~online_b;
    assign controller_health_pulse = hw_q;
    assign unit_a_redundant_flag_n = 1'b0;
    assign unit_b_redundant_flag_n = 1'b0;
    assign unit_b_address_offset_n = 1'b0;
    assign manual_mode             = manual;
    assign switch_problem          = prob_q;
endmodule : rsc_ctrl

// ==== hw/rsc_filter.sv ====
`include "rsc_cfg.svh"
module rsc_filter
    import rsc_pkg::*;
#(
    parameter int HOLD_MS = `RSC_DEBOUNCE_MS
)
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ms_tick,
    input  wire logic raw,
    output logic      clean
);
    localparam logic [15:0] HOLD = 16'(HOLD_MS);
    logic        s1_q;
    logic        s2_q;
    logic        clean_q;
    logic        clean_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;

    always_comb
    begin
        clean_d = clean_q;
        cnt_d   = cnt_q;
        if (s2_q == clean_q)
        begin
            cnt_d = 16'h0000;
        end
        else if (ms_tick)
        begin
            if (cnt_q + 16'h0001 >= HOLD)
            begin
                clean_d = s2_q;
                cnt_d   = 16'h0000;
            end
            else
            begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_q    <= 1'b1;
            s2_q    <= 1'b1;
            clean_q <= 1'b1;
            cnt_q   <= 16'h0000;
        end
        else
        begin
            s1_q    <= raw;
            s2_q    <= s1_q;
            clean_q <= clean_d;
            cnt_q   <= cnt_d;
        end
    end

    assign clean = clean_q;
endmodule : rsc_filter

// ==== hw/rsc_pkg.sv ====
package rsc_pkg;
    typedef enum logic [1:0] {
        RSC_IDLE,
        RSC_PULSE,
        RSC_SETTLE
    } rsc_state_e;
    typedef struct packed {
        logic pos_a_cmd;
        logic pos_b_cmd;
    } rsc_sw_cmd_s;
    typedef struct packed {
        logic pos_a_ind;
        logic pos_b_ind;
    } rsc_sw_ind_s;
endpackage : rsc_pkg

// ==== tb/rsc_ctrl_assertions.sv ====
module rsc_ctrl_chk
    import rsc_pkg::*;
#(
    parameter int PULSE_MS  = 350,
    parameter int MS_CYCLES = 25000
)
(
    input wire logic        clk,
    input wire logic        rst,
    input wire rsc_sw_cmd_s tx_cmd,
    input wire rsc_sw_cmd_s rx_cmd,
    input wire logic        unit_a_online_contact,
    input wire logic        unit_b_online_contact,
    input wire logic        unit_a_position_n,
    input wire logic        unit_b_position_n,
    input wire logic        controller_health_pulse,
    input wire logic        unit_a_redundant_flag_n,
    input wire logic        unit_b_redundant_flag_n,
    input wire logic        unit_b_address_offset_n,
    input wire logic        switch_problem
);
    localparam int PULSE_CYC = PULSE_MS * MS_CYCLES;
    int   cnt_q;
    int   cnt_d;
    logic on;
    assign on = tx_cmd.pos_a_cmd | tx_cmd.pos_b_cmd;
    // length of the running command pulse
    always_comb cnt_d = on ? cnt_q + 1 : 0;
    always_ff @(posedge clk) cnt_q <= rst ? 0 : cnt_d;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence swap_to_b;
        $rose(tx_cmd.pos_b_cmd);
    endsequence
    sequence pulse_end;
        $fell(on);
    endsequence
    chk_cmd_paired: assert property (tx_cmd == rx_cmd)
        else $error("tx and rx commands differ");
    chk_cmd_single: assert property (!(tx_cmd.pos_a_cmd && tx_cmd.pos_b_cmd))
        else $error("both command lines high");
    chk_pulse_max: assert property (on |-> cnt_q < PULSE_CYC)
        else $error("command pulse too long");
    chk_pulse_len: assert property (pulse_end |-> cnt_q == PULSE_CYC)
        else $error("command pulse wrong length");
    chk_online_excl: assert property (unit_a_online_contact != unit_b_online_contact)
        else $error("online contacts not exclusive");
    chk_position_map: assert property ({unit_a_position_n, unit_b_position_n}
        == {!unit_a_online_contact, !unit_b_online_contact}) else $error("position out wrong");
    chk_flags_ground: assert property (!unit_a_redundant_flag_n
        && !unit_b_redundant_flag_n && !unit_b_address_offset_n)
        else $error("flag output not grounded");
    chk_health_stop: assert property (switch_problem [*2] |-> !controller_health_pulse)
        else $error("health pulse runs on problem");
    chk_swap_online: assert property (swap_to_b |-> unit_a_online_contact)
        else $error("move to b while b online");
endmodule : rsc_ctrl_chk
bind rsc_ctrl rsc_ctrl_chk #(.PULSE_MS(PULSE_MS), .MS_CYCLES(MS_CYCLES)) i_chk (
    .clk(clk), .rst(rst), .tx_cmd(tx_cmd), .rx_cmd(rx_cmd),
    .unit_a_online_contact(unit_a_online_contact), .unit_b_online_contact(unit_b_online_contact),
    .unit_a_position_n(unit_a_position_n), .unit_b_position_n(unit_b_position_n),
    .controller_health_pulse(controller_health_pulse),
    .unit_a_redundant_flag_n(unit_a_redundant_flag_n),
    .unit_b_redundant_flag_n(unit_b_redundant_flag_n),
    .unit_b_address_offset_n(unit_b_address_offset_n), .switch_problem(switch_problem));

// ==== tb/rsc_switch_model.sv ====
module rsc_switch_model
    import rsc_pkg::*;
(
    input  wire logic  clk,
    input  rsc_sw_cmd_s cmd,
    output rsc_sw_ind_s ind_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic at_b_q = 1'b0;
    // rests where the last command pulse sent it
    always @(posedge clk)
        at_b_q <= cmd.pos_b_cmd | (at_b_q & ~cmd.pos_a_cmd);
    assign ind_n = {at_b_q, ~at_b_q};
endmodule : rsc_switch_model

// ==== tb/tb.sv ====
module tb
    import rsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
        $display("BAD %0t %h %h", $time, g, e); end end
    int          err_count = 0;
    int          compares = 0;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        msel = 1'b1, swp_n = 1'b1, rswp = 1'b0, rman = 1'b0, aflt = 1'b0, bflt = 1'b0;
    logic        a_on, b_on, a_fc, b_fc, a_pos_n, b_pos_n, hp, a_red_n, b_red_n, b_ofs_n, man;
    logic        prob;
    rsc_sw_cmd_s tx_cmd, rx_cmd;
    rsc_sw_ind_s tx_ind_n, rx_ind_n;
    rsc_ctrl #(.PULSE_MS(350), .SWAP_MIN_MS(100), .HEALTH_HALF_MS(50), .SETTLE_MS(20),
        .MS_CYCLES(4)) i_dut (.clk(clk), .rst(rst), .redundancy_mode_select(msel),
        .swap_request_n(swp_n), .remote_swap_command(rswp), .remote_mode_manual(rman),
        .unit_a_health_input(aflt), .unit_b_health_input(bflt), .tx_ind_n(tx_ind_n),
        .rx_ind_n(rx_ind_n), .tx_cmd(tx_cmd), .rx_cmd(rx_cmd), .unit_a_online_contact(a_on),
        .unit_b_online_contact(b_on), .unit_a_fault_contact(a_fc), .unit_b_fault_contact(b_fc),
        .unit_a_position_n(a_pos_n), .unit_b_position_n(b_pos_n), .controller_health_pulse(hp),
        .unit_a_redundant_flag_n(a_red_n), .unit_b_redundant_flag_n(b_red_n),
        .unit_b_address_offset_n(b_ofs_n), .manual_mode(man), .switch_problem(prob));
    rsc_switch_model i_tx_sw (.clk(clk), .cmd(tx_cmd), .ind_n(tx_ind_n));
    rsc_switch_model i_rx_sw (.clk(clk), .cmd(rx_cmd), .ind_n(rx_ind_n));
    task automatic close_out();
        if (err_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic rpulse();
        rswp = 1'b1;
        cyc(1);
        rswp = 1'b0;
    endtask : rpulse
    task automatic swapped(input logic to_b);
        int i;
        i = 0;
        while (i < 600 && tx_cmd !== {!to_b, to_b})
        begin
            i++;
            cyc(1);
        end
        `CHK({tx_cmd, rx_cmd}, {!to_b, to_b, !to_b, to_b})
        cyc(1700);
        `CHK({a_on, b_on, a_pos_n, b_pos_n}, {!to_b, to_b, to_b, !to_b})
        `CHK(prob, 1'b0)
    endtask : swapped
    task automatic quiet(input int n);
        int hit;
        hit = 0;
        repeat (n)
        begin
            cyc(1);
            hit += (tx_cmd !== 2'b00);
        end
        `CHK(hit, 0)
    endtask : quiet
    task automatic s_idle();
        int   i;
        logic h;
        cyc(100);
        `CHK({a_on, b_on, a_pos_n, b_pos_n}, 4'b1001)
        `CHK({a_red_n, b_red_n, b_ofs_n}, 3'b000)
        `CHK({man, a_fc, b_fc}, 3'b000)
        `CHK(prob, 1'b0)
        repeat (2)
        begin
            h = hp;
            i = 0;
            while (i < 300 && hp === h)
            begin
                i++;
                cyc(1);
            end
        end
        `CHK(i, 200)
    endtask : s_idle
    task automatic s_manual();
        msel = 1'b0;
        aflt = 1'b1;
        bflt = 1'b1;
        cyc(60);
        `CHK({man, a_fc, b_fc}, 3'b111)
        rpulse();
        swapped(1'b1);
        swp_n = 1'b0;
        swapped(1'b0);
        swp_n = 1'b1;
        quiet(500);
        swp_n = 1'b0;
        quiet(300);
        swp_n = 1'b1;
    endtask : s_manual
    task automatic s_auto();
        msel = 1'b1;
        aflt = 1'b0;
        bflt = 1'b0;
        cyc(500);
        `CHK({man, a_fc, b_fc}, 3'b000)
        aflt = 1'b1;
        swapped(1'b1);
        rpulse();
        quiet(300);
        swp_n = 1'b0;
        quiet(410);
        swp_n = 1'b1;
        bflt = 1'b1;
        quiet(500);
        rman = 1'b1;
        cyc(60);
        `CHK(man, 1'b1)
        rpulse();
        swapped(1'b0);
        rman = 1'b0;
        msel = 1'b0;
        cyc(60);
        `CHK(man, 1'b1)
    endtask : s_auto
    initial
    begin
        forever #20 clk = ~clk;
    end
    initial
    begin
        #(40 * 40000);
        err_count++;
        close_out();
    end
    initial
    begin
        cyc(16);
        rst = 1'b0;
        s_idle();
        s_manual();
        s_auto();
        close_out();
    end
endmodule : tb
